// >>> hw/sstw_pkg.sv
// Shared constants for the two-wire slave port and its bus master.
// Assumes both ends run on mclk at 40 MHz.
package sstw_pkg;
  // Register indices on the software port
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_BUF  = 3'h2;
  localparam logic [2:0] REG_ADDR = 3'h3;
  localparam logic [2:0] REG_DIR  = 3'h4;
  localparam logic [2:0] REG_FLAG = 3'h5;
  // Control fields
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_OV_BIT = 6;
  // Status fields
  localparam int STAT_BF_BIT = 0;
  localparam int STAT_UA_BIT = 1;
  localparam int STAT_RW_BIT = 2;
  localparam int STAT_S_BIT  = 3;
  localparam int STAT_P_BIT  = 4;
  localparam int STAT_DA_BIT = 5;
  // Interrupt flag position, direction bits for clock and data pins
  localparam int FLAG_BIT     = 3;
  localparam int DIR_SCL_BIT  = 3;
  localparam int DIR_SDA_BIT  = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'hFF;
  localparam logic [7:0] ADDR_RST = 8'h00;
  // Mode codes
  localparam logic [3:0] MODE_S7    = 4'h6;
  localparam logic [3:0] MODE_S10   = 4'h7;
  localparam logic [3:0] MODE_S7I   = 4'hE;
  localparam logic [3:0] MODE_S10I  = 4'hF;
  localparam logic [3:0] MODE_FWMST = 4'hB;
  // High byte marker of a 10-bit address
  localparam logic [4:0] TEN_HI_MARK = 5'h1E;
  // Link timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int QTR_CYC_RAW    = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_CYC        = (QTR_CYC_RAW < 1) ? 1 : QTR_CYC_RAW;
  // Host commands
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_STOP  = 2'h3;
endpackage

// >>> hw/sstw_if.sv
// Two-wire link between the slave port and the bus master.
// Each party gives output and an active-low enable per pin; the wires resolve here.
`timescale 1ns/1ps
interface sstw_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;

  // Open drain with pull-up: any enabled low wins
  assign scl = !((!dev_scl_oe_n && !dev_scl_o) || (!host_scl_oe_n && !host_scl_o));
  assign sda = !((!dev_sda_oe_n && !dev_sda_o) || (!host_sda_oe_n && !host_sda_o));

  modport dev  (input scl, sda, output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

// >>> hw/sstw_slave.sv
// Two-wire slave port: registers, address match, double-buffered receive.
// Assumes a bus master on the link and software on the plain register port.
//
// What this block does
// - Four-bit mode field selects four slave operations
// - Enabled two-wire mode drives pins open-drain
// - Status register is read-only to software
// - Completed byte moves to buffer, sets flag
// - Data byte over full buffer sets overflow, discarded
// - Software loads high then low address
// - Slave transmitter overrides data pin
// - Match or data byte gets acknowledge
// - Full or overflow withholds ack, still flags
// - Buffer read clears full; software clears overflow
// - Wait for start, sample on rising
// - Compare address bits on eighth falling edge
// - Match loads buffer, acks, flags ninth fall
// - Ten-bit marker; write direction gets second byte
// - First ten-bit byte sets update-address
// - Second byte sets update-address again
// - Repeated start high byte for transmit
// - Master keeps clock high and low times
// - Port active only with enable bit
// - Seven and ten-bit slave, no general call
`timescale 1ns/1ps
module sstw_slave import sstw_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Software register port
  input  wire logic [2:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata_q,
  output logic            port_interrupt_flag_q,
  // Link
  sstw_if.dev             link
);
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RX   = 5'b00010,
    D_ACK  = 5'b00100,
    D_TX   = 5'b01000,
    D_TACK = 5'b10000
  } sstw_dst_t;

  sstw_dst_t  st_q, st_d;
  logic [7:0] ctrl_q, ctrl_d, addr_q, addr_d, dir_q, dir_d, buf_q, buf_d, sr_q, sr_d;
  logic [7:0] rdata_d;
  logic [3:0] cnt_q, cnt_d;
  logic       bf_q, bf_d, ua_q, ua_d, rw_q, rw_d, s_q, s_d, p_q, p_d, da_q, da_d;
  logic       flag_d, in_addr_q, in_addr_d, second_q, second_d, ten_ok_q, ten_ok_d;
  logic       ok_q, ok_d, hit_q, hit_d, hold_q, hold_d, sda_oe_n_d, scl_oe_n_d;
  logic       scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic       rise, fall, start, stop, ten, ints, active, hit, ok;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge mclk) begin
    scl_m_q <= link.scl;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= link.sda;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  assign rise  = scl_s_q && !scl_p_q;
  assign fall  = !scl_s_q && scl_p_q;
  assign start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  assign ten  = (ctrl_q[3:0] == MODE_S10) || (ctrl_q[3:0] == MODE_S10I);
  assign ints = (ctrl_q[3:0] == MODE_S7I) || (ctrl_q[3:0] == MODE_S10I);
  assign active = ctrl_q[CTRL_EN_BIT] && dir_q[DIR_SCL_BIT] && dir_q[DIR_SDA_BIT] &&
                  (ten || ints || ctrl_q[3:0] == MODE_S7);

  always_comb begin
    hit = 1'b1;
    if (in_addr_q && second_q) begin
      hit = (sr_q == addr_q);
    end else if (in_addr_q) begin
      hit = (sr_q[7:1] == addr_q[7:1]) &&
            (!ten || ((sr_q[7:3] == TEN_HI_MARK) && (!sr_q[0] || ten_ok_q)));
    end
    ok = hit && !bf_q && !ctrl_q[CTRL_OV_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and link engine
  always_comb begin
    st_d = st_q; ctrl_d = ctrl_q; addr_d = addr_q; dir_d = dir_q; buf_d = buf_q;
    sr_d = sr_q; cnt_d = cnt_q; bf_d = bf_q; ua_d = ua_q; rw_d = rw_q; s_d = s_q;
    p_d = p_q; da_d = da_q; flag_d = port_interrupt_flag_q; in_addr_d = in_addr_q;
    second_d = second_q; ten_ok_d = ten_ok_q; ok_d = ok_q; hit_d = hit_q;
    hold_d = hold_q; sda_oe_n_d = link.dev_sda_oe_n; rdata_d = 8'h00;
    if (sw_wr) begin
      unique case (sw_addr)
        REG_CTRL: ctrl_d = sw_wdata;
        REG_BUF: begin
          buf_d = sw_wdata;
          if (st_q == D_TX) hold_d = 1'b0;
        end
        REG_ADDR: begin
          addr_d = sw_wdata;
          if (ua_q) begin
            ua_d   = 1'b0;
            hold_d = 1'b0;
          end
        end
        REG_DIR:  dir_d = sw_wdata;
        REG_FLAG: flag_d = sw_wdata[FLAG_BIT];
        default: ;
      endcase
    end
    if (sw_rd) begin
      unique case (sw_addr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_STAT: rdata_d = {2'h0, da_q, p_q, s_q, rw_q, ua_q, bf_q};
        REG_BUF: begin
          rdata_d = buf_q;
          bf_d = 1'b0;
        end
        REG_ADDR: rdata_d = addr_q;
        REG_DIR:  rdata_d = dir_q;
        REG_FLAG: rdata_d = {4'h0, port_interrupt_flag_q, 3'h0};
        default:  rdata_d = 8'h00;
      endcase
    end
    if (!active) begin
      st_d = D_IDLE; hold_d = 1'b0; sda_oe_n_d = 1'b1;
    end else if (start) begin
      s_d = 1'b1; p_d = 1'b0; st_d = D_RX; cnt_d = 4'h0;
      in_addr_d = 1'b1; second_d = 1'b0; sda_oe_n_d = 1'b1;
      if (ints) flag_d = 1'b1;
    end else if (stop) begin
      s_d = 1'b0; p_d = 1'b1; st_d = D_IDLE; ten_ok_d = 1'b0; sda_oe_n_d = 1'b1;
      if (ints) flag_d = 1'b1;
    end else begin
      unique case (st_q)
        D_IDLE: ;
        D_RX: begin
          if (rise) begin
            sr_d  = {sr_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            ok_d = ok; hit_d = hit; sda_oe_n_d = !ok; st_d = D_ACK;
            if (hit && !in_addr_q && bf_q) ctrl_d[CTRL_OV_BIT] = 1'b1;
          end
        end
        D_ACK: begin
          if (fall) begin
            sda_oe_n_d = 1'b1; cnt_d = 4'h0; st_d = D_RX;
            if (hit_q) flag_d = 1'b1;
            if (ok_q) begin
              buf_d = sr_q; bf_d = 1'b1;
            end
            if (!ok_q) begin
              st_d = D_IDLE;
            end else if (in_addr_q && second_q) begin
              ua_d = 1'b1; hold_d = 1'b1; in_addr_d = 1'b0; ten_ok_d = 1'b1; da_d = 1'b0;
            end else if (in_addr_q) begin
              rw_d = sr_q[0]; da_d = 1'b0; in_addr_d = 1'b0;
              if (sr_q[0]) begin
                st_d = D_TX; hold_d = 1'b1;
              end else if (ten) begin
                ua_d = 1'b1; hold_d = 1'b1; in_addr_d = 1'b1; second_d = 1'b1;
              end
            end else begin
              da_d = 1'b1;
            end
          end
        end
        D_TX: begin
          if (!hold_q && cnt_q == 4'h0) begin
            sr_d = buf_q; sda_oe_n_d = buf_q[7]; cnt_d = 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            sda_oe_n_d = 1'b1; st_d = D_TACK;
          end else if (fall && cnt_q != 4'h0) begin
            sr_d = {sr_q[6:0], 1'b0}; sda_oe_n_d = sr_q[6]; cnt_d = cnt_q + 4'h1;
          end
        end
        D_TACK: begin
          if (rise) begin
            ok_d = !sda_s_q;
          end else if (fall) begin
            flag_d = 1'b1; cnt_d = 4'h0;
            if (ok_q) begin
              st_d = D_TX; hold_d = 1'b1;
            end else begin
              st_d = D_IDLE;
            end
          end
        end
        default: st_d = D_IDLE;
      endcase
    end
    scl_oe_n_d = !(hold_d && active);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= D_IDLE; ctrl_q <= CTRL_RST; addr_q <= ADDR_RST; dir_q <= DIR_RST;
      buf_q <= 8'h00; sr_q <= 8'h00; cnt_q <= 4'h0; bf_q <= 1'b0; ua_q <= 1'b0;
      rw_q <= 1'b0; s_q <= 1'b0; p_q <= 1'b0; da_q <= 1'b0; in_addr_q <= 1'b0;
      second_q <= 1'b0; ten_ok_q <= 1'b0; ok_q <= 1'b0; hit_q <= 1'b0; hold_q <= 1'b0;
      port_interrupt_flag_q <= 1'b0; sw_rdata_q <= 8'h00;
      link.dev_sda_oe_n <= 1'b1; link.dev_scl_oe_n <= 1'b1;
      link.dev_sda_o <= 1'b0; link.dev_scl_o <= 1'b0;
    end else begin
      st_q <= st_d; ctrl_q <= ctrl_d; addr_q <= addr_d; dir_q <= dir_d;
      buf_q <= buf_d; sr_q <= sr_d; cnt_q <= cnt_d; bf_q <= bf_d; ua_q <= ua_d;
      rw_q <= rw_d; s_q <= s_d; p_q <= p_d; da_q <= da_d; in_addr_q <= in_addr_d;
      second_q <= second_d; ten_ok_q <= ten_ok_d; ok_q <= ok_d; hit_q <= hit_d;
      hold_q <= hold_d; port_interrupt_flag_q <= flag_d; sw_rdata_q <= rdata_d;
      link.dev_sda_oe_n <= sda_oe_n_d; link.dev_scl_oe_n <= scl_oe_n_d;
      link.dev_sda_o <= 1'b0; link.dev_scl_o <= 1'b0;
    end
  end
endmodule

// >>> hw/sstw_master.sv
// Two-wire bus master: start, byte write, byte read, stop on command.
// Assumes one command at a time from user logic; clock made from mclk.
`timescale 1ns/1ps
module sstw_master import sstw_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Command port
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_ack,
  output logic            busy_q,
  output logic            done_q,
  output logic      [7:0] rx_byte_q,
  output logic            rx_ack_q,
  // Link
  sstw_if.host            link
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BIT   = 4'b0100,
    H_STOP  = 4'b1000
  } sstw_hst_t;

  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  sstw_hst_t  st_q, st_d;
  logic [7:0] qc_q, qc_d, rx_byte_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [8:0] tx_q, tx_d, rx_q, rx_d;
  logic       scl_m_q, scl_s_q, sda_m_q, sda_s_q, tick;
  logic       scl_oe_n_d, sda_oe_n_d, busy_d, done_d, rx_ack_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge mclk) begin
    scl_m_q <= link.scl;
    scl_s_q <= scl_m_q;
    sda_m_q <= link.sda;
    sda_s_q <= sda_m_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-period sequencer
  always_comb begin
    st_d = st_q; qc_d = qc_q; ph_d = ph_q; cnt_d = cnt_q; tx_d = tx_q; rx_d = rx_q;
    scl_oe_n_d = link.host_scl_oe_n; sda_oe_n_d = link.host_sda_oe_n;
    busy_d = busy_q; done_d = 1'b0; rx_byte_d = rx_byte_q; rx_ack_d = rx_ack_q;
    tick = (qc_q == QTR_LAST);
    qc_d = tick ? 8'h00 : qc_q + 8'h01;
    unique case (st_q)
      H_IDLE: begin
        qc_d = 8'h00; ph_d = 2'h0; cnt_d = 4'h0;
        if (cmd_valid) begin
          busy_d = 1'b1;
          unique case (cmd_op)
            OP_START: st_d = H_START;
            OP_WRITE: begin
              st_d = H_BIT; tx_d = {cmd_byte, 1'b1};
            end
            OP_READ: begin
              st_d = H_BIT; tx_d = {8'hFF, !cmd_ack};
            end
            OP_STOP: st_d = H_STOP;
          endcase
        end
      end
      default: begin
        // clock high waits for a stretched line
        if (tick && !(ph_q == 2'h2 && !scl_s_q)) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_n_d = (st_q == H_STOP) ? 1'b0 :
                               (st_q == H_BIT) ? tx_q[8] : 1'b1;
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: begin
              if (st_q == H_START) sda_oe_n_d = 1'b0;
              if (st_q == H_BIT) rx_d = {rx_q[7:0], sda_s_q};
            end
            2'h3: begin
              if (st_q == H_STOP) begin
                sda_oe_n_d = 1'b1;
              end else begin
                scl_oe_n_d = 1'b0;
              end
              tx_d  = {tx_q[7:0], 1'b1};
              cnt_d = cnt_q + 4'h1;
              if (st_q != H_BIT || cnt_q == 4'h8) begin
                st_d = H_IDLE; busy_d = 1'b0; done_d = 1'b1;
                rx_byte_d = rx_q[8:1];
                rx_ack_d  = !rx_q[0];
              end
            end
          endcase
        end else if (tick) begin
          qc_d = QTR_LAST;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= H_IDLE; qc_q <= 8'h00; ph_q <= 2'h0; cnt_q <= 4'h0;
      tx_q <= 9'h1FF; rx_q <= 9'h000; busy_q <= 1'b0; done_q <= 1'b0;
      rx_byte_q <= 8'h00; rx_ack_q <= 1'b0;
      link.host_scl_oe_n <= 1'b1; link.host_sda_oe_n <= 1'b1;
      link.host_scl_o <= 1'b0; link.host_sda_o <= 1'b0;
    end else begin
      st_q <= st_d; qc_q <= qc_d; ph_q <= ph_d; cnt_q <= cnt_d;
      tx_q <= tx_d; rx_q <= rx_d; busy_q <= busy_d; done_q <= done_d;
      rx_byte_q <= rx_byte_d; rx_ack_q <= rx_ack_d;
      link.host_scl_oe_n <= scl_oe_n_d; link.host_sda_oe_n <= sda_oe_n_d;
      link.host_scl_o <= 1'b0; link.host_sda_o <= 1'b0;
    end
  end
endmodule

// >>> tb/sstw_properties.sv
// Checker for the two-wire link between the slave port and the master.
// Assumes the signals of one sstw_if, all in the mclk domain.
`timescale 1ns/1ps
module sstw_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Device side of the link
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  // Resolved wires
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] falls_q;
  logic [3:0] falls_d;
  logic       scl_q;
  logic       sda_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Clock falls since the last start, saturating
  always_comb begin
    falls_d = falls_q;
    if (scl && scl_q && sda_q && !sda) begin
      falls_d = 4'h0;
    end else if (scl_q && !scl && falls_q != 4'hF) begin
      falls_d = falls_q + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      falls_q <= 4'hF;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      falls_q <= falls_d;
      scl_q   <= scl;
      sda_q   <= sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sda_open_drain: assert property (dev_sda_o == 1'b0)
    else $error("device drives sda high");
  a_scl_open_drain: assert property (dev_scl_o == 1'b0)
    else $error("device drives scl high");
  a_idle_after_reset: assert property ($fell(sys_rst) |-> dev_scl_oe_n && dev_sda_oe_n)
    else $error("lines held after reset");
  a_quiet_address: assert property (falls_q < 4'h8 |-> dev_sda_oe_n)
    else $error("sda driven inside the address byte");
  a_sda_moves_low: assert property ($changed(dev_sda_oe_n) |-> !$past(scl))
    else $error("sda changed while scl high");
  a_ack_holds: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*4])
    else $error("sda drive too short");
  a_ack_released: assert property ($fell(dev_sda_oe_n) |-> ##[4:150] dev_sda_oe_n)
    else $error("sda never released");
  a_stretch_low: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("scl pulled while high");
  a_scl_min_high: assert property ($rose(scl) |-> scl [*2])
    else $error("scl high too short");
  a_scl_min_low: assert property ($fell(scl) |-> !scl [*2])
    else $error("scl low too short");
endmodule

// >>> tb/tb.sv
// Bench joining the slave port and the bus master over one link.
// Assumes mclk at 40 MHz; software and master commands driven here.
`timescale 1ns/1ps
module tb import sstw_pkg::*;;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr = 1'b0;
  logic       sw_rd = 1'b0;
  logic [7:0] sw_rdata_q;
  logic       irq_flag;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_byte = 8'h00;
  logic       cmd_ack = 1'b0;
  logic       busy_q;
  logic       done_q;
  logic       rx_ack_q;
  logic [7:0] rx_byte_q;
  int         err_count = 0;
  int         n_checks = 0;

  sstw_if link ();
  sstw_slave i_sstw_slave (.mclk(mclk), .sys_rst(sys_rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q),
    .port_interrupt_flag_q(irq_flag), .link(link));
  sstw_master i_sstw_master (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack), .busy_q(busy_q),
    .done_q(done_q), .rx_byte_q(rx_byte_q), .rx_ack_q(rx_ack_q), .link(link));
  sstw_properties u_props (.mclk(mclk), .sys_rst(sys_rst), .dev_scl_o(link.dev_scl_o),
    .dev_scl_oe_n(link.dev_scl_oe_n), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));

  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 check($sformatf("reg%0d", a), sw_rdata_q & m, e);
    @(posedge mclk);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] b, input logic ak);
    int i;
    cmd_op    <= op;
    cmd_byte  <= b;
    cmd_ack   <= ak;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1 check("busy", {7'h0, busy_q}, 8'h01);
    for (i = 0; i < 4000; i++) begin
      @(posedge mclk);
      #1 if (done_q === 1'b1) break;
    end
    if (i == 4000) begin
      err_count++;
      results();
    end
    // Slave sees the lines three cycles late; let its flags settle
    repeat (4) @(posedge mclk);
  endtask
  // Byte write with expected acknowledge; slave flags land a few cycles on
  task automatic sendb(input logic [7:0] b, input logic ak);
    cmd(OP_WRITE, b, 1'b0);
    check("ack", {7'h0, rx_ack_q}, {7'h0, ak});
    repeat (4) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(REG_CTRL, CTRL_RST, 8'hFF);
    rd(REG_DIR, DIR_RST, 8'hFF);
    rd(REG_ADDR, ADDR_RST, 8'hFF);
    wr(REG_STAT, 8'hFF);
    rd(REG_STAT, 8'h00, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    wr(REG_ADDR, 8'h5A);
    // Port disabled, then firmware-master mode, then pins as outputs: no answer
    wr(REG_CTRL, 8'h06);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h5A, 1'b0);
    wr(REG_CTRL, 8'h2B);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h5A, 1'b0);
    wr(REG_CTRL, 8'h26);
    wr(REG_DIR, 8'hE7);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h5A, 1'b0);
    wr(REG_DIR, 8'hFF);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Seven-bit receive, full buffer and overflow
    wr(REG_FLAG, 8'h00);
    cmd(OP_START, 8'h00, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h00);
    sendb(8'h5A, 1'b1);
    rd(REG_STAT, 8'h01, 8'h27);
    check("flag", {7'h0, irq_flag}, 8'h01);
    rd(REG_BUF, 8'h5A, 8'hFF);
    rd(REG_STAT, 8'h00, 8'h01);
    wr(REG_FLAG, 8'h00);
    sendb(8'hC3, 1'b1);
    rd(REG_STAT, 8'h21, 8'h21);
    wr(REG_FLAG, 8'h00);
    sendb(8'h3C, 1'b0);
    rd(REG_CTRL, 8'h66, 8'hFF);
    check("flag", {7'h0, irq_flag}, 8'h01);
    rd(REG_BUF, 8'hC3, 8'hFF);
    // A refused byte ends the transfer; overflow alone still refuses the address
    wr(REG_FLAG, 8'h00);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h5A, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h01);
    rd(REG_STAT, 8'h00, 8'h01);
    wr(REG_CTRL, 8'h26);
    rd(REG_CTRL, 8'h26, 8'hFF);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h5A, 1'b1);
    rd(REG_BUF, 8'h5A, 8'hFF);
    sendb(8'h22, 1'b1);
    rd(REG_BUF, 8'h22, 8'hFF);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Address mismatch, then start flag in mode E
    wr(REG_FLAG, 8'h00);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'h70, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    wr(REG_CTRL, 8'h2E);
    cmd(OP_START, 8'h00, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h01);
    // Seven-bit transmit
    wr(REG_CTRL, 8'h26);
    sendb(8'h5B, 1'b1);
    rd(REG_STAT, 8'h04, 8'h04);
    rd(REG_BUF, 8'h5B, 8'hFF);
    wr(REG_BUF, 8'h96);
    cmd(OP_READ, 8'h00, 1'b0);
    check("rxbyte", rx_byte_q, 8'h96);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Ten-bit write, then repeated start and transmit
    wr(REG_CTRL, 8'h27);
    wr(REG_ADDR, 8'hF6);
    cmd(OP_START, 8'h00, 1'b0);
    sendb(8'hF6, 1'b1);
    rd(REG_STAT, 8'h03, 8'h07);
    wr(REG_ADDR, 8'h34);
    rd(REG_STAT, 8'h01, 8'h03);
    rd(REG_BUF, 8'hF6, 8'hFF);
    sendb(8'h34, 1'b1);
    rd(REG_STAT, 8'h03, 8'h03);
    wr(REG_ADDR, 8'hF6);
    rd(REG_STAT, 8'h01, 8'h03);
    rd(REG_BUF, 8'h34, 8'hFF);
    wr(REG_FLAG, 8'h00);
    cmd(OP_START, 8'h00, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h00);
    sendb(8'hF7, 1'b1);
    check("flag", {7'h0, irq_flag}, 8'h01);
    rd(REG_BUF, 8'hF7, 8'hFF);
    wr(REG_BUF, 8'hA5);
    cmd(OP_READ, 8'h00, 1'b0);
    check("rxbyte", rx_byte_q, 8'hA5);
    // Stop flag in mode F
    wr(REG_CTRL, 8'h2F);
    wr(REG_FLAG, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    check("flag", {7'h0, irq_flag}, 8'h01);
    results();
  end
endmodule
